// *** verilog/ldrb_pkg.sv ***
// Package: register map, field positions and reset values of the LED driver register bank
package ldrb_pkg;

  // ***************************************************
  // Register offsets
  // ***************************************************
  localparam logic [7:0] LDRB_ADDR_SHUTDOWN    = 8'h00;
  localparam logic [7:0] LDRB_ADDR_CH_EN_LOW   = 8'h01;
  localparam logic [7:0] LDRB_ADDR_CH_EN_HIGH  = 8'h02;
  localparam logic [7:0] LDRB_ADDR_OP_CFG      = 8'h03;
  localparam logic [7:0] LDRB_ADDR_CUR_GAIN    = 8'h04;
  localparam logic [7:0] LDRB_ADDR_RAMP_HOLD   = 8'h05;
  localparam logic [7:0] LDRB_ADDR_MARKER      = 8'h06;
  localparam logic [7:0] LDRB_ADDR_DUTY_FIRST  = 8'h07;
  localparam logic [7:0] LDRB_ADDR_DUTY_LAST   = 8'h0f;
  localparam logic [7:0] LDRB_ADDR_OUT_COMMIT  = 8'h10;
  localparam logic [7:0] LDRB_ADDR_DELAY_FIRST = 8'h11;
  localparam logic [7:0] LDRB_ADDR_DELAY_LAST  = 8'h19;
  localparam logic [7:0] LDRB_ADDR_RAMP_FIRST  = 8'h1a;
  localparam logic [7:0] LDRB_ADDR_RAMP_LAST   = 8'h1c;
  localparam logic [7:0] LDRB_ADDR_OFF_FIRST   = 8'h1d;
  localparam logic [7:0] LDRB_ADDR_OFF_LAST    = 8'h25;
  localparam logic [7:0] LDRB_ADDR_TIME_COMMIT = 8'h26;
  localparam logic [7:0] LDRB_ADDR_RESTORE     = 8'hff;

  // ***************************************************
  // Commit value and writable-bit masks
  // ***************************************************
  localparam logic [7:0] LDRB_COMMIT_VALUE     = 8'h00;
  localparam logic [7:0] LDRB_MASK_SHUTDOWN    = 8'h01;
  localparam logic [7:0] LDRB_MASK_CH_EN_LOW   = 8'h77;
  localparam logic [7:0] LDRB_MASK_CH_EN_HIGH  = 8'h07;
  localparam logic [7:0] LDRB_MASK_OP_CFG      = 8'h77;
  localparam logic [7:0] LDRB_MASK_CUR_GAIN    = 8'hf7;
  localparam logic [7:0] LDRB_MASK_RAMP_HOLD   = 8'h77;
  localparam logic [7:0] LDRB_MASK_MARKER      = 8'h1f;
  localparam logic [7:0] LDRB_MASK_DELAY       = 8'h3f;
  localparam logic [7:0] LDRB_MASK_RAMP_TIME   = 8'hf7;
  localparam logic [7:0] LDRB_MASK_OFF         = 8'h3f;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [7:0] LDRB_RST_SHUTDOWN     = 8'h00;
  localparam logic [7:0] LDRB_RST_CH_EN_LOW    = 8'h77;
  localparam logic [7:0] LDRB_RST_CH_EN_HIGH   = 8'h07;
  localparam logic [7:0] LDRB_RST_CONFIG       = 8'h00;
  localparam logic [7:0] LDRB_RST_TIME         = 8'h00;
  localparam logic [7:0] LDRB_RST_DUTY         = 8'h00;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int LDRB_POS_MARKER_EN  = 4;
  localparam int LDRB_POS_CH_LO_A    = 0;
  localparam int LDRB_POS_CH_LO_B    = 4;
  localparam int LDRB_POS_GRP_MODE   = 4;
  localparam int LDRB_POS_AUDIO_EN   = 2;
  localparam int LDRB_POS_AGC_EN_N   = 1;
  localparam int LDRB_POS_AGC_SPEED  = 0;
  localparam int LDRB_POS_CASCADE    = 7;
  localparam int LDRB_POS_CURRENT    = 4;
  localparam int LDRB_POS_GAIN       = 0;
  localparam int LDRB_POS_RAMP_EN    = 4;
  localparam int LDRB_POS_HOLD_SEL   = 0;
  localparam logic [3:0] LDRB_MARKER_CH_MAX = 4'h8;

endpackage : ldrb_pkg

// *** verilog/ldrb_register_bank.sv ***
// Write-only register bank of the nine-channel LED driver, shadowed with commit strobes
//
// How it works
// - Shutdown bit zero keeps device shut down
// - Low enable register: channels 1-3, 4-6
// - High enable register: channels 7-9, upper zero
// - Enable bits store each channel on/off
// - Group mode bits pick duty or breathing
// - Automatic gain enabled when bit is zero
// - Automatic gain speed: fast zero, slow one
// - Cascade role: master zero, slave one
// - Three-bit code selects maximum output current
// - Three-bit audio gain in 3 dB steps
// - Per-group ramping enable bits
// - Per-group hold phase: T2 or T4
// - Nine duty registers in channel order
// - Output commit loads pending duty and enables
// - Commit needs value zero; else keep active
// - Timing commit loads pending timing values
// - Timing commit needs zero; pending stays hidden
// - Restore register returns all defaults
// - Per-channel start delay timing registers
// - Marker enable plus valid channel select
module ldrb_register_bank
  import ldrb_pkg::*;
#(
  parameter int NUM_CH  = 9,
  parameter int NUM_GRP = 3
)(
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_n_i,
  // Register write port from the serial bus slave
  input  wire logic                 wr_en_i,
  input  wire logic [7:0]           wr_addr_i,
  input  wire logic [7:0]           wr_data_i,
  // Global controls
  output logic                      soft_power_down_o,
  output logic [NUM_CH-1:0]         channel_on_bit_o,
  output logic [NUM_GRP-1:0]        group_mode_select_o,
  output logic                      audio_brightness_enable_o,
  output logic                      auto_level_enable_n_o,
  output logic                      auto_level_speed_o,
  output logic                      cascade_role_o,
  output logic [2:0]                current_code_o,
  output logic [2:0]                audio_gain_code_o,
  output logic [NUM_GRP-1:0]        ramp_enable_o,
  output logic [NUM_GRP-1:0]        hold_phase_select_o,
  output logic                      marker_enable_o,
  output logic [3:0]                marker_channel_o,
  output logic                      marker_valid_o,
  // Active per-channel and per-group values
  output logic [NUM_CH*8-1:0]       duty_o,
  output logic [NUM_CH*8-1:0]       start_delay_time_o,
  output logic [NUM_GRP*8-1:0]      rise_hold_fall_time_o,
  output logic [NUM_CH*8-1:0]       off_time_o
);

  // ***************************************************
  // Write decode
  // ***************************************************
  logic       restore;
  logic       out_commit;
  logic       time_commit;
  logic [7:0] cfg_shutdown_q;
  logic [7:0] cfg_op_q;
  logic [7:0] cfg_cur_q;
  logic [7:0] cfg_ramp_q;
  logic [7:0] cfg_marker_q;
  logic [7:0] en_low_sh_q;
  logic [7:0] en_high_sh_q;
  logic [7:0] en_low_q;
  logic [7:0] en_high_q;
  logic [7:0] duty_sh_q  [NUM_CH];
  logic [7:0] duty_q     [NUM_CH];
  logic [7:0] delay_sh_q [NUM_CH];
  logic [7:0] delay_q    [NUM_CH];
  logic [7:0] off_sh_q   [NUM_CH];
  logic [7:0] off_q      [NUM_CH];
  logic [7:0] ramp_sh_q  [NUM_GRP];
  logic [7:0] ramp_q     [NUM_GRP];

  // Restore is taken on any data; the commit strobes only on zero
  assign restore     = wr_en_i && (wr_addr_i == LDRB_ADDR_RESTORE);
  assign out_commit  = wr_en_i && (wr_addr_i == LDRB_ADDR_OUT_COMMIT)
                       && (wr_data_i == LDRB_COMMIT_VALUE);
  assign time_commit = wr_en_i && (wr_addr_i == LDRB_ADDR_TIME_COMMIT)
                       && (wr_data_i == LDRB_COMMIT_VALUE);

  // ***************************************************
  // Unshadowed configuration registers
  // ***************************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_shutdown_q <= LDRB_RST_SHUTDOWN;
      cfg_op_q       <= LDRB_RST_CONFIG;
      cfg_cur_q      <= LDRB_RST_CONFIG;
      cfg_ramp_q     <= LDRB_RST_CONFIG;
      cfg_marker_q   <= LDRB_RST_CONFIG;
    end
    else if (restore)
    begin
      cfg_shutdown_q <= LDRB_RST_SHUTDOWN;
      cfg_op_q       <= LDRB_RST_CONFIG;
      cfg_cur_q      <= LDRB_RST_CONFIG;
      cfg_ramp_q     <= LDRB_RST_CONFIG;
      cfg_marker_q   <= LDRB_RST_CONFIG;
    end
    else if (wr_en_i)
    begin
      // Unused bits are masked so they are always stored as zero
      if (wr_addr_i == LDRB_ADDR_SHUTDOWN)
        cfg_shutdown_q <= wr_data_i & LDRB_MASK_SHUTDOWN;
      else if (wr_addr_i == LDRB_ADDR_OP_CFG)
        cfg_op_q <= wr_data_i & LDRB_MASK_OP_CFG;
      else if (wr_addr_i == LDRB_ADDR_CUR_GAIN)
        cfg_cur_q <= wr_data_i & LDRB_MASK_CUR_GAIN;
      else if (wr_addr_i == LDRB_ADDR_RAMP_HOLD)
        cfg_ramp_q <= wr_data_i & LDRB_MASK_RAMP_HOLD;
      else if (wr_addr_i == LDRB_ADDR_MARKER)
        cfg_marker_q <= wr_data_i & LDRB_MASK_MARKER;
    end
  end

  // ***************************************************
  // Channel enables: shadow then active
  // ***************************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      en_low_sh_q  <= LDRB_RST_CH_EN_LOW;
      en_high_sh_q <= LDRB_RST_CH_EN_HIGH;
    end
    else if (restore)
    begin
      en_low_sh_q  <= LDRB_RST_CH_EN_LOW;
      en_high_sh_q <= LDRB_RST_CH_EN_HIGH;
    end
    else if (wr_en_i && (wr_addr_i == LDRB_ADDR_CH_EN_LOW))
      en_low_sh_q <= wr_data_i & LDRB_MASK_CH_EN_LOW;
    else if (wr_en_i && (wr_addr_i == LDRB_ADDR_CH_EN_HIGH))
      en_high_sh_q <= wr_data_i & LDRB_MASK_CH_EN_HIGH;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      en_low_q  <= LDRB_RST_CH_EN_LOW;
      en_high_q <= LDRB_RST_CH_EN_HIGH;
    end
    else if (restore)
    begin
      en_low_q  <= LDRB_RST_CH_EN_LOW;
      en_high_q <= LDRB_RST_CH_EN_HIGH;
    end
    else if (out_commit)
    begin
      en_low_q  <= en_low_sh_q;
      en_high_q <= en_high_sh_q;
    end
  end

  // ***************************************************
  // Per-channel duty and timing registers, per-group ramp timing registers
  // ***************************************************
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      localparam logic [7:0] DUTY_A  = 8'(LDRB_ADDR_DUTY_FIRST + c);
      localparam logic [7:0] DELAY_A = 8'(LDRB_ADDR_DELAY_FIRST + c);
      localparam logic [7:0] OFF_A   = 8'(LDRB_ADDR_OFF_FIRST + c);

      always_ff @(posedge clk_sys_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          duty_sh_q[c]  <= LDRB_RST_DUTY;
          delay_sh_q[c] <= LDRB_RST_TIME;
          off_sh_q[c]   <= LDRB_RST_TIME;
        end
        else if (restore)
        begin
          duty_sh_q[c]  <= LDRB_RST_DUTY;
          delay_sh_q[c] <= LDRB_RST_TIME;
          off_sh_q[c]   <= LDRB_RST_TIME;
        end
        else if (wr_en_i)
        begin
          if (wr_addr_i == DUTY_A)
            duty_sh_q[c] <= wr_data_i;
          else if (wr_addr_i == DELAY_A)
            delay_sh_q[c] <= wr_data_i & LDRB_MASK_DELAY;
          else if (wr_addr_i == OFF_A)
            off_sh_q[c] <= wr_data_i & LDRB_MASK_OFF;
        end
      end

      always_ff @(posedge clk_sys_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          duty_q[c]  <= LDRB_RST_DUTY;
          delay_q[c] <= LDRB_RST_TIME;
          off_q[c]   <= LDRB_RST_TIME;
        end
        else if (restore)
        begin
          duty_q[c]  <= LDRB_RST_DUTY;
          delay_q[c] <= LDRB_RST_TIME;
          off_q[c]   <= LDRB_RST_TIME;
        end
        else
        begin
          if (out_commit)
            duty_q[c] <= duty_sh_q[c];
          if (time_commit)
          begin
            delay_q[c] <= delay_sh_q[c];
            off_q[c]   <= off_sh_q[c];
          end
        end
      end

      assign duty_o[c*8 +: 8]             = duty_q[c];
      assign start_delay_time_o[c*8 +: 8] = delay_q[c];
      assign off_time_o[c*8 +: 8]         = off_q[c];
    end

    for (genvar g = 0; g < NUM_GRP; g++)
    begin : g_grp
      localparam logic [7:0] RAMP_A = 8'(LDRB_ADDR_RAMP_FIRST + g);

      always_ff @(posedge clk_sys_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          ramp_sh_q[g] <= LDRB_RST_TIME;
          ramp_q[g]    <= LDRB_RST_TIME;
        end
        else if (restore)
        begin
          ramp_sh_q[g] <= LDRB_RST_TIME;
          ramp_q[g]    <= LDRB_RST_TIME;
        end
        else
        begin
          if (wr_en_i && (wr_addr_i == RAMP_A))
            ramp_sh_q[g] <= wr_data_i & LDRB_MASK_RAMP_TIME;
          if (time_commit)
            ramp_q[g] <= ramp_sh_q[g];
        end
      end

      assign rise_hold_fall_time_o[g*8 +: 8] = ramp_q[g];
    end
  endgenerate

  // ***************************************************
  // Decoded controls
  // ***************************************************
  // Shutdown is active while the stored bit is clear
  assign soft_power_down_o = ~cfg_shutdown_q[0];
  // A set bit turns the channel on, a clear one turns it off
  assign channel_on_bit_o  = {en_high_q[2:0],
                              en_low_q[LDRB_POS_CH_LO_B +: 3],
                              en_low_q[LDRB_POS_CH_LO_A +: 3]};
  assign group_mode_select_o       = cfg_op_q[LDRB_POS_GRP_MODE +: NUM_GRP];
  assign audio_brightness_enable_o = cfg_op_q[LDRB_POS_AUDIO_EN];
  // Stored bit is already the active-low enable
  assign auto_level_enable_n_o     = cfg_op_q[LDRB_POS_AGC_EN_N];
  assign auto_level_speed_o        = cfg_op_q[LDRB_POS_AGC_SPEED];
  assign cascade_role_o            = cfg_cur_q[LDRB_POS_CASCADE];
  assign current_code_o            = cfg_cur_q[LDRB_POS_CURRENT +: 3];
  assign audio_gain_code_o         = cfg_cur_q[LDRB_POS_GAIN +: 3];
  assign ramp_enable_o             = cfg_ramp_q[LDRB_POS_RAMP_EN +: NUM_GRP];
  assign hold_phase_select_o       = cfg_ramp_q[LDRB_POS_HOLD_SEL +: NUM_GRP];
  assign marker_enable_o           = cfg_marker_q[LDRB_POS_MARKER_EN];
  assign marker_channel_o          = cfg_marker_q[3:0];
  // Codes above channel nine are stored but flagged unusable
  assign marker_valid_o            = (cfg_marker_q[3:0] <= LDRB_MARKER_CH_MAX);

endmodule : ldrb_register_bank

// *** verif/ldrb_register_bank_checker.sv ***
// Checker: port-level relations of the LED driver register bank
module ldrb_register_bank_checker
  import ldrb_pkg::*;
#(
  parameter int NUM_CH  = 9,
  parameter int NUM_GRP = 3
)(
  // Clock, reset and write port
  input wire logic                clk_sys_i,
  input wire logic                reset_n_i,
  input wire logic                wr_en_i,
  input wire logic [7:0]          wr_addr_i,
  input wire logic [7:0]          wr_data_i,
  // Controls and active values
  input wire logic                soft_power_down_o,
  input wire logic [NUM_CH-1:0]   channel_on_bit_o,
  input wire logic [NUM_GRP-1:0]  group_mode_select_o,
  input wire logic                audio_brightness_enable_o,
  input wire logic                auto_level_enable_n_o,
  input wire logic                auto_level_speed_o,
  input wire logic                cascade_role_o,
  input wire logic [2:0]          current_code_o,
  input wire logic [2:0]          audio_gain_code_o,
  input wire logic [NUM_GRP-1:0]  ramp_enable_o,
  input wire logic [NUM_GRP-1:0]  hold_phase_select_o,
  input wire logic                marker_enable_o,
  input wire logic [3:0]          marker_channel_o,
  input wire logic                marker_valid_o,
  input wire logic [NUM_CH*8-1:0] duty_o,
  input wire logic [NUM_CH*8-1:0] start_delay_time_o,
  input wire logic [NUM_GRP*8-1:0] rise_hold_fall_time_o,
  input wire logic [NUM_CH*8-1:0] off_time_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire logic wr_at[0:6];
  wire logic zero = wr_data_i == LDRB_COMMIT_VALUE;
  wire logic rst = wr_en_i && wr_addr_i == LDRB_ADDR_RESTORE;
  wire logic cmt = wr_en_i && wr_addr_i == LDRB_ADDR_OUT_COMMIT && zero;
  wire logic tcm = wr_en_i && wr_addr_i == LDRB_ADDR_TIME_COMMIT && zero;
  wire logic far = wr_en_i && wr_addr_i > LDRB_ADDR_TIME_COMMIT && !rst;
  for (genvar k = 0; k < 7; k++)
  begin : g_at
    assign wr_at[k] = wr_en_i && wr_addr_i == 8'(k);
  end

  shut_follow_a :
    assert property (wr_at[0] |=> soft_power_down_o == !$past(wr_data_i[0]))
    else $error("shutdown output does not follow bit 0");
  reset_dflt_a :
    assert property ($rose(reset_n_i) |-> soft_power_down_o && &channel_on_bit_o && duty_o == '0)
    else $error("outputs not at defaults after reset");
  enable_hold_a :
    assert property (!cmt && !rst |=> $stable(channel_on_bit_o) && $stable(duty_o))
    else $error("enables or duty changed without commit");
  timing_hold_a :
    assert property (!tcm && !rst |=> $stable(start_delay_time_o) && $stable(off_time_o))
    else $error("timing changed without commit");
  op_cfg_a :
    assert property (wr_at[3] |=> {group_mode_select_o, audio_brightness_enable_o,
      auto_level_enable_n_o, auto_level_speed_o} == {$past(wr_data_i[6:4]), $past(wr_data_i[2:0])})
    else $error("operation config not stored");
  cur_gain_a :
    assert property (wr_at[4] |=> {cascade_role_o, current_code_o, audio_gain_code_o}
      == {$past(wr_data_i[7:4]), $past(wr_data_i[2:0])})
    else $error("current or gain config not stored");
  ramp_hold_a :
    assert property (wr_at[5] |=> {ramp_enable_o, hold_phase_select_o}
      == {$past(wr_data_i[6:4]), $past(wr_data_i[2:0])})
    else $error("ramp or hold config not stored");
  marker_flag_a :
    assert property (wr_at[6] |=> {marker_enable_o, marker_channel_o, marker_valid_o}
      == {$past(wr_data_i[4:0]), !($past(wr_data_i[3]) && ($past(wr_data_i[2:0]) != 3'h0))})
    else $error("marker field or valid flag wrong");
  restore_all_a :
    assert property (rst |=> soft_power_down_o && &channel_on_bit_o && off_time_o == '0
      && current_code_o == 3'h0 && duty_o == '0)
    else $error("restore did not return defaults");
  far_ignore_a :
    assert property (far |=> $stable(soft_power_down_o) && $stable(current_code_o))
    else $error("unmapped write changed a register");
  commit_c : cover property (cmt);
  restore_c : cover property (rst);
  bad_marker_c : cover property (!marker_valid_o);
endmodule : ldrb_register_bank_checker

bind ldrb_register_bank ldrb_register_bank_checker #(.NUM_CH(NUM_CH), .NUM_GRP(NUM_GRP)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .soft_power_down_o(soft_power_down_o),
  .channel_on_bit_o(channel_on_bit_o), .group_mode_select_o(group_mode_select_o),
  .audio_brightness_enable_o(audio_brightness_enable_o),
  .auto_level_enable_n_o(auto_level_enable_n_o), .auto_level_speed_o(auto_level_speed_o),
  .cascade_role_o(cascade_role_o), .current_code_o(current_code_o),
  .audio_gain_code_o(audio_gain_code_o), .ramp_enable_o(ramp_enable_o),
  .hold_phase_select_o(hold_phase_select_o), .marker_enable_o(marker_enable_o),
  .marker_channel_o(marker_channel_o), .marker_valid_o(marker_valid_o), .duty_o(duty_o),
  .start_delay_time_o(start_delay_time_o), .rise_hold_fall_time_o(rise_hold_fall_time_o),
  .off_time_o(off_time_o));

// *** verif/ldrb_host_model.sv ***
// Host model: the bus-side writer feeding bytes into the register bank
module ldrb_host_model
  import ldrb_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  // Write port
  output logic            wr_en_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    wr_en_o   = 1'b0;
    wr_addr_o = 8'h27;
    wr_data_o = 8'h00;
  end
  // A gap cycle follows each byte, so the strobe is never driven twice in one step
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 {wr_en_o, wr_addr_o, wr_data_o} = {1'b1, a, d};
    @(posedge clk_sys_i);
    // Released lines show the inverse so stale values are never mistaken for data
    #1 {wr_en_o, wr_addr_o, wr_data_o} = {1'b0, ~a, ~d};
  endtask : write_byte
  task automatic commit_out();
    write_byte(LDRB_ADDR_OUT_COMMIT, LDRB_COMMIT_VALUE);
  endtask : commit_out
  task automatic commit_time();
    write_byte(LDRB_ADDR_TIME_COMMIT, LDRB_COMMIT_VALUE);
  endtask : commit_time
endmodule : ldrb_host_model

// *** verif/testbench.sv ***
// Testbench: directed write sequences against the LED driver register bank
module testbench
  import ldrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        en, spd, aud, agn, asp, cas, men, mval;
  logic [7:0]  addr, data;
  logic [8:0]  chon;
  logic [2:0]  grp, cur, gain, ramp, hold;
  logic [3:0]  mch;
  logic [71:0] duty, dly, off;
  logic [23:0] rise;
  int          errors = 0;
  int          checked = 0;

  ldrb_host_model u_ldrb_host_model (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .wr_en_o(en), .wr_addr_o(addr), .wr_data_o(data));
  ldrb_register_bank u_ldrb_register_bank (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .wr_en_i(en), .wr_addr_i(addr), .wr_data_i(data), .soft_power_down_o(spd),
    .channel_on_bit_o(chon), .group_mode_select_o(grp), .audio_brightness_enable_o(aud),
    .auto_level_enable_n_o(agn), .auto_level_speed_o(asp), .cascade_role_o(cas),
    .current_code_o(cur), .audio_gain_code_o(gain), .ramp_enable_o(ramp),
    .hold_phase_select_o(hold), .marker_enable_o(men), .marker_channel_o(mch),
    .marker_valid_o(mval), .duty_o(duty), .start_delay_time_o(dly),
    .rise_hold_fall_time_o(rise), .off_time_o(off));

  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [71:0] s, input logic [71:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ldrb_host_model.write_byte(a, d);
  endtask : wr
  task automatic defaults();
    chk({spd, chon, grp, aud, agn, asp, cas, cur, gain}, {1'b1, 9'h1ff, 13'h0});
    chk({ramp, hold, men, mch, mval}, {11'h0, 1'b1});
    chk(duty, '0);
    chk(dly, '0);
    chk(off, '0);
    chk(rise, '0);
  endtask : defaults
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #2000000 errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    defaults();
    $display("test reset defaults done");
    wr(LDRB_ADDR_SHUTDOWN, 8'hff);
    chk(spd, 1'b0);
    wr(LDRB_ADDR_OP_CFG, 8'hff);
    chk({grp, aud, agn, asp}, 6'h3f);
    for (int c = 0; c < 8; c++)
    begin
      wr(LDRB_ADDR_CUR_GAIN, 8'(c * 17 + 8'h88));
      chk({cas, cur, gain}, {1'b1, 3'(c), 3'(c)});
    end
    wr(LDRB_ADDR_RAMP_HOLD, 8'hd2);
    chk({ramp, hold}, 6'h2a);
    wr(8'h40, 8'h00);
    chk({spd, cur}, 4'h7);
    $display("test config done");
    wr(LDRB_ADDR_CH_EN_LOW, 8'h8d);
    wr(LDRB_ADDR_CH_EN_HIGH, 8'hfa);
    for (int i = 0; i < 9; i++)
      wr(8'(LDRB_ADDR_DUTY_FIRST + i), 8'(8'h10 + i));
    wr(LDRB_ADDR_OUT_COMMIT, 8'h01);
    chk(chon, 9'h1ff);
    chk(duty, 72'h0);
    u_ldrb_host_model.commit_out();
    chk(chon, 9'b010_000_101);
    for (int i = 0; i < 9; i++)
      chk(duty[i*8 +: 8], 8'(8'h10 + i));
    $display("test output commit done");
    wr(LDRB_ADDR_DELAY_FIRST, 8'hff);
    wr(LDRB_ADDR_RAMP_FIRST, 8'hff);
    wr(LDRB_ADDR_OFF_LAST, 8'hc5);
    wr(LDRB_ADDR_TIME_COMMIT, 8'h55);
    chk(dly, '0);
    chk(off, '0);
    chk(rise, '0);
    u_ldrb_host_model.commit_time();
    chk({dly[7:0], rise[7:0], off[71:64]}, 24'h3ff705);
    $display("test timing commit done");
    wr(LDRB_ADDR_MARKER, 8'hf8);
    chk({men, mch, mval}, 6'h31);
    wr(LDRB_ADDR_MARKER, 8'h09);
    chk({men, mch, mval}, 6'h12);
    $display("test marker done");
    wr(LDRB_ADDR_RESTORE, 8'ha5);
    defaults();
    $display("test restore done");
    wr(LDRB_ADDR_DUTY_FIRST, 8'h44);
    wr(LDRB_ADDR_SHUTDOWN, 8'h01);
    @(posedge clk_sys_i);
    #1 reset_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    u_ldrb_host_model.commit_out();
    defaults();
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : testbench
